// ==== sim/ztbs_mem_master.sv ====
// memory controller model turning per-cycle commands into sram pin levels
`timescale 1ns/1ps
`default_nettype none
module ztbs_mem_master (
   // commands: 0 deselect, 1 load read, 2 load write, 3 advance
   input wire logic pclk,
   input wire logic [1:0] op,
   input wire logic [16:0] addr,
   input wire logic [35:0] wdata,
   input wire logic [3:0] bw_n,
   input wire logic freeze,
   // sram pins
   output logic [16:0] mem_addr,
   output logic read_not_write,
   output logic advance_or_load,
   output logic operation_hold_n,
   output logic chip_select_low_a,
   output logic chip_select_low_b,
   output logic chip_select_high,
   output logic [3:0] byte_lane_write_n,
   output logic [31:0] data_bus_in,
   output logic [3:0] data_bus_extra_bits_in
);
   logic dir_w = 1'b0;
   logic [35:0] wd_q = 36'h0_0000_0000;
   assign mem_addr = addr;
   assign read_not_write = op != 2'd2;
   assign advance_or_load = op == 2'd3;
   assign operation_hold_n = freeze;
   // deselect drops the select picked by the low address bits
   assign chip_select_low_a = op == 2'd0 && addr[1:0] == 2'd0;
   assign chip_select_low_b = op == 2'd0 && addr[1:0] == 2'd1;
   assign chip_select_high = !(op == 2'd0 && addr[1]);
   assign byte_lane_write_n = bw_n;
   assign data_bus_in = wd_q[31:0];
   assign data_bus_extra_bits_in = wd_q[35:32];
   // write data one cycle late, otherwise changing junk
   always @(posedge pclk) begin
      if (!freeze) begin
         wd_q <= (op == 2'd2 || (op == 2'd3 && dir_w)) ? wdata : ~wd_q;
         if (op != 2'd3) dir_w <= op == 2'd2;
      end
   end
endmodule : ztbs_mem_master
`default_nettype wire

// ==== sim/ztbs_sram_bench.sv ====
// self-checking bench for the burst sram against an array model
`timescale 1ns/1ps
`default_nettype none
module ztbs_sram_bench;
   import ztbs_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [1:0] op = 2'd0;
   logic [16:0] addr = 17'h0_0000;
   logic [35:0] wdata = 36'h0_0000_0000;
   logic [3:0] bw_n = 4'hf;
   logic freeze = 1'b0, burst_order_select = 1'b0, output_enable_n = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [16:0] mem_addr, base, cur;
   logic read_not_write, advance_or_load, operation_hold_n, chip_select_low_a, chip_select_low_b, chip_select_high;
   logic [3:0] byte_lane_write_n, data_bus_extra_bits_in, data_bus_extra_bits_out;
   logic [31:0] data_bus_in, data_bus_out, prdata, r;
   logic data_bus_oe, data_bus_extra_bits_oe, pready, pslverr, e;
   logic [35:0] mem [DEPTH];
   logic [35:0] exp_d;
   logic [1:0] cnt;
   logic act = 1'b0, dir = 1'b0, inh = 1'b0, exp_oe = 1'b0;
   int bad_count = 0, n_compared = 0, cyc = 0;
   always #2 pclk = ~pclk;
   ztbs_mem_master ztbs_mem_master_inst (.pclk, .op, .addr, .wdata, .bw_n, .freeze, .mem_addr, .read_not_write,
      .advance_or_load, .operation_hold_n, .chip_select_low_a, .chip_select_low_b, .chip_select_high,
      .byte_lane_write_n, .data_bus_in, .data_bus_extra_bits_in);
   ztbs_sram ztbs_sram_inst (.pclk, .presetn, .mem_addr, .read_not_write, .advance_or_load, .operation_hold_n,
      .chip_select_low_a, .chip_select_low_b, .chip_select_high, .byte_lane_write_n, .burst_order_select,
      .output_enable_n, .data_bus_in, .data_bus_out, .data_bus_oe, .data_bus_extra_bits_in,
      .data_bus_extra_bits_out, .data_bus_extra_bits_oe, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr);
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [35:0] x, input logic [35:0] s);
      n_compared++;
      if (s !== x) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   function automatic logic [35:0] rw();
      return {4'($urandom), 32'($urandom)};
   endfunction : rw
   task automatic step(input logic [1:0] o, input logic [16:0] a, input logic [35:0] d, input logic [3:0] b,
      input logic f, input logic n);
      @(posedge pclk);
      op <= o;
      addr <= a;
      wdata <= d;
      bw_n <= b;
      freeze <= f;
      output_enable_n <= n;
   endtask : step
   task automatic rnd(input int n);
      repeat (n) step(2'($urandom), 17'($urandom % 16), rw(), 4'($urandom), $urandom % 6 == 0, $urandom % 7 == 0);
      step(2'd0, 17'h0_0000, rw(), 4'hf, 1'b0, 1'b0);
   endtask : rnd
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // array model, advanced on every edge where freeze is low
   always @(posedge pclk) begin
      if (!presetn) begin
         act = 1'b0;
         exp_oe = 1'b0;
      end else if (!freeze) begin
         if (op == 2'd0) act = 1'b0;
         else if (op != 2'd3) begin
            base = addr;
            cnt = 2'd0;
            dir = op[1];
            act = 1'b1;
         end else if (act) cnt = cnt + 2'd1;
         exp_oe = act && !dir;
         if (act) begin
            cur = {base[16:2], burst_order_select ? base[1:0] ^ cnt : base[1:0] + cnt};
            for (int i = 0; i < 4; i++) begin
               if (dir && !inh && !bw_n[i]) begin
                  mem[cur][8*i+:8] = wdata[8*i+:8];
                  mem[cur][32+i] = wdata[32+i];
               end
            end
            exp_d = mem[cur];
         end
      end
   end
   always @(negedge pclk) begin
      if (presetn) begin
         chk("oe", {2{exp_oe && !output_enable_n}}, {data_bus_oe, data_bus_extra_bits_oe});
         if (exp_oe && !output_enable_n) chk("rdata", exp_d, {data_bus_extra_bits_out, data_bus_out});
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'hafcdb223));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0000_0000);
      chk("ctrl", 36'h0_0000_0000, {4'h0, r});
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("unmapped", 36'h1_0000_0000, {3'h0, e, r});
      $display("test apb done");
      for (int b = 0; b < 20; b += 4) begin
         step(2'd2, b == 16 ? 17'h1_fffc : 17'(b), rw(), 4'h0, 1'b0, 1'b0);
         repeat (3) step(2'd3, 17'h0_0000, rw(), 4'h0, 1'b0, 1'b0);
      end
      step(2'd1, 17'h1_ffff, rw(), 4'hf, 1'b0, 1'b0);
      rnd(400);
      $display("test linear done");
      burst_order_select <= 1'b1;
      rnd(400);
      $display("test interleaved done");
      step(2'd2, 17'h0_0005, rw(), 4'h0, 1'b0, 1'b0);
      repeat (2) step(2'd3, 17'h0_0000, rw(), 4'h5, 1'b0, 1'b0);
      step(2'd0, 17'h0_0000, rw(), 4'hf, 1'b1, 1'b0);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk("status", {30'h0, cnt, 1'b0, dir, act, act}, {4'h0, r});
      step(2'd0, 17'h0_0000, rw(), 4'hf, 1'b0, 1'b0);
      $display("test freeze done");
      apb(1'b1, REG_CTRL, 32'h0000_0001);
      inh = 1'b1;
      rnd(300);
      apb(1'b0, REG_CTRL, 32'h0000_0000);
      chk("ctrl", 36'h0_0000_0001, {4'h0, r});
      apb(1'b1, REG_CTRL, 32'h0000_0000);
      inh = 1'b0;
      rnd(200);
      $display("test inhibit done");
      final_report();
   end
endmodule : ztbs_sram_bench
`default_nettype wire

// ==== verilog/ztbs_burst_if.sv ====
// burst sequence request and offset between controller and sequencer
`timescale 1ns/1ps
`default_nettype none
interface ztbs_burst_if;
   import ztbs_pkg::*;
   logic [BURST_W-1:0] base;
   logic [BURST_W-1:0] count;
   logic interleaved;
   logic [BURST_W-1:0] offset;
   modport ctrl (output base, output count, output interleaved, input offset);
   modport seq (input base, input count, input interleaved, output offset);
endinterface : ztbs_burst_if
`default_nettype wire

// ==== verilog/ztbs_burst_seq.sv ====
// burst address sequencer, linear or interleaved
`timescale 1ns/1ps
`default_nettype none
module ztbs_burst_seq (
   // sequence request and offset
   ztbs_burst_if.seq bif
);
   import ztbs_pkg::*;

   always_comb begin
      if (bif.interleaved) begin
         bif.offset = bif.base ^ bif.count;
      end else begin
         bif.offset = bif.base + bif.count;
      end
   end
endmodule : ztbs_burst_seq
`default_nettype wire

// ==== verilog/ztbs_pkg.sv ====
// constants and state types for the zero turnaround burst sram
`default_nettype none
package ztbs_pkg;
   // array organisation, 128K words of four 9-bit lanes
   localparam int ADDR_W = 17;
   localparam int DEPTH = 131072;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORD_W = LANES * LANE_W;
   localparam int BYTE_W = 8;
   localparam int DATA_W = LANES * BYTE_W;
   localparam int BURST_W = 2;

   // apb register map, byte addresses
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;

   // control and status field positions
   localparam int CTRL_WR_INHIBIT = 0;
   localparam int STAT_BURST_ACTIVE = 0;
   localparam int STAT_XFER_PENDING = 1;
   localparam int STAT_XFER_WRITE = 2;
   localparam int STAT_BURST_COUNT = 4;

   // values after reset
   localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
   localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;
   localparam logic [3:0] BW_RESET = 4'hf;

   typedef struct packed {
      logic wr_inhibit;
      logic [31:0] prdata;
      logic [ADDR_W-BURST_W-1:0] addr_hi;
      logic [BURST_W-1:0] base;
      logic [BURST_W-1:0] count;
      logic burst_active;
      logic cyc_valid;
      logic cyc_write;
      logic [ADDR_W-1:0] cyc_addr;
      logic [LANES-1:0] cyc_bw_n;
   } ztbs_state_t;
endpackage : ztbs_pkg
`default_nettype wire

// ==== verilog/ztbs_sram.sv ====
// zero turnaround burst sram with flow-through reads and apb status
`timescale 1ns/1ps
`default_nettype none
module ztbs_sram (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // memory address and control
   input wire logic [ztbs_pkg::ADDR_W-1:0] mem_addr,
   input wire logic read_not_write,
   input wire logic advance_or_load,
   input wire logic operation_hold_n,
   input wire logic chip_select_low_a,
   input wire logic chip_select_low_b,
   input wire logic chip_select_high,
   input wire logic [ztbs_pkg::LANES-1:0] byte_lane_write_n,
   input wire logic burst_order_select,
   input wire logic output_enable_n,
   // data bus, split into in, out and enable
   input wire logic [ztbs_pkg::DATA_W-1:0] data_bus_in,
   output logic [ztbs_pkg::DATA_W-1:0] data_bus_out,
   output logic data_bus_oe,
   input wire logic [ztbs_pkg::LANES-1:0] data_bus_extra_bits_in,
   output logic [ztbs_pkg::LANES-1:0] data_bus_extra_bits_out,
   output logic data_bus_extra_bits_oe,
   // apb slave
   input wire logic [ztbs_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import ztbs_pkg::*;

   ztbs_state_t st;
   ztbs_state_t next_st;
   logic selected;
   logic enabled;
   logic drive;
   logic array_write;
   logic apb_access;
   logic apb_mapped;
   logic [WORD_W-1:0] rd_word;
   logic [WORD_W-1:0] mem [0:DEPTH-1];

   ztbs_burst_if bif ();

   ztbs_burst_seq u_seq (
      .bif(bif)
   );

   // next position within the burst
   assign bif.base = st.base;
   assign bif.count = st.count + 2'h1;
   assign bif.interleaved = burst_order_select;

   assign enabled = ~operation_hold_n;
   assign selected = ~chip_select_low_a & ~chip_select_low_b & chip_select_high;
   assign apb_access = psel & penable;
   assign apb_mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS);

   always_comb begin
      next_st = st;
      // memory pipeline only moves on enabled edges
      if (enabled) begin
         if (!advance_or_load) begin
            if (selected) begin
               next_st.addr_hi = mem_addr[ADDR_W-1:BURST_W];
               next_st.base = mem_addr[BURST_W-1:0];
               next_st.count = COUNT_RESET;
               next_st.burst_active = 1'b1;
               next_st.cyc_valid = 1'b1;
               next_st.cyc_write = ~read_not_write;
               next_st.cyc_addr = mem_addr;
               next_st.cyc_bw_n = byte_lane_write_n;
            end else begin
               next_st.burst_active = 1'b0;
               next_st.cyc_valid = 1'b0;
               next_st.cyc_write = 1'b0;
               next_st.cyc_bw_n = BW_RESET;
            end
         end else if (st.burst_active) begin
            next_st.count = bif.count;
            next_st.cyc_valid = 1'b1;
            next_st.cyc_addr = {st.addr_hi, bif.offset};
            next_st.cyc_bw_n = byte_lane_write_n;
         end else begin
            next_st.cyc_valid = 1'b0;
            next_st.cyc_write = 1'b0;
            next_st.cyc_bw_n = BW_RESET;
         end
      end
      // apb read data captured in the setup cycle
      if (psel && !penable) begin
         next_st.prdata = PRDATA_RESET;
         if (paddr == REG_CTRL) begin
            next_st.prdata[CTRL_WR_INHIBIT] = st.wr_inhibit;
         end else if (paddr == REG_STATUS) begin
            next_st.prdata[STAT_BURST_ACTIVE] = st.burst_active;
            next_st.prdata[STAT_XFER_PENDING] = st.cyc_valid;
            next_st.prdata[STAT_XFER_WRITE] = st.cyc_write;
            next_st.prdata[STAT_BURST_COUNT +: BURST_W] = st.count;
         end
      end
      if (apb_access && pwrite && paddr == REG_CTRL) begin
         next_st.wr_inhibit = pwdata[CTRL_WR_INHIBIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.cyc_bw_n <= BW_RESET;
      end else begin
         st <= next_st;
      end
   end

   // array write straight from the data-in bus during the pending cycle
   assign array_write = enabled & st.cyc_valid & st.cyc_write & ~st.wr_inhibit;

   always_ff @(posedge pclk) begin
      if (array_write) begin
         for (int i = 0; i < LANES; i++) begin
            if (!st.cyc_bw_n[i]) begin
               mem[st.cyc_addr][i*LANE_W +: LANE_W] <= {data_bus_extra_bits_in[i], data_bus_in[i*BYTE_W +: BYTE_W]};
            end
         end
      end
   end

   // flow-through read of the pending address
   assign rd_word = mem[st.cyc_addr];

   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         data_bus_out[i*BYTE_W +: BYTE_W] = rd_word[i*LANE_W +: BYTE_W];
         data_bus_extra_bits_out[i] = rd_word[i*LANE_W + BYTE_W];
      end
   end

   // drivers on only for a pending read, cut at once by output enable
   assign drive = st.cyc_valid & ~st.cyc_write & ~output_enable_n;
   assign data_bus_oe = drive;
   assign data_bus_extra_bits_oe = drive;

   // apb answers with no wait state
   assign prdata = st.prdata;
   assign pready = 1'b1;
   assign pslverr = apb_access & ~apb_mapped;

   AST_LOAD_READ_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected && read_not_write)
      |=> (st.cyc_valid && !st.cyc_write && st.cyc_addr == $past(mem_addr)))
      else $error("read load did not become pending one cycle later");

   AST_WRITE_THEN_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected && !read_not_write)
      ##1 (enabled && !advance_or_load && selected && read_not_write)
      |=> (st.cyc_valid && !st.cyc_write))
      else $error("read after write lost a cycle");

   AST_HOLD_FREEZES: assert property (@(posedge pclk) disable iff (!presetn)
      !enabled |=> $stable({st.cyc_valid, st.cyc_write, st.cyc_addr, st.count, st.burst_active}))
      else $error("pipeline moved while clock enable was high");

   AST_DESELECT_NO_OP: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && !selected) |=> !st.cyc_valid)
      else $error("deselect started an operation");

   AST_WRITE_FLOATS: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && (selected ? !read_not_write : 1'b1)) |=> !data_bus_oe)
      else $error("data bus driven after write start or deselect");

   AST_BURST_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected && !burst_order_select)
      ##1 (enabled && advance_or_load && !burst_order_select) [*3]
      |=> (st.cyc_valid && st.cyc_addr[1:0] == $past(st.cyc_addr[1:0], 3) + 2'h3))
      else $error("linear burst did not reach its fourth word");

   AST_INTERLEAVE_XOR: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && advance_or_load && st.burst_active && burst_order_select)
      |=> (st.cyc_addr[1:0] == ($past(st.base) ^ ($past(st.count) + 2'h1))))
      else $error("interleaved burst offset wrong");

   AST_OE_ASYNC: assert property (@(posedge pclk) disable iff (!presetn)
      output_enable_n |-> (!data_bus_oe && !data_bus_extra_bits_oe))
      else $error("data bus driven with output enable off");

   AST_DESELECT_ENDS_BURST: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && !selected) ##1 (enabled && advance_or_load) |=> !st.cyc_valid)
      else $error("burst continued after deselect");

   AST_LANE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (array_write && !st.cyc_bw_n[0])
      |=> (mem[$past(st.cyc_addr)][LANE_W-1:0] == {$past(data_bus_extra_bits_in[0]), $past(data_bus_in[7:0])}))
      else $error("lane zero not written");

   AST_PENDING_WRITE_DONE: assert property (@(posedge pclk) disable iff (!presetn)
      (st.cyc_valid && st.cyc_write && enabled && !st.wr_inhibit && !advance_or_load && !selected)
      |-> array_write)
      else $error("pending write dropped on deselect");

   // pipeline capture on load and advance edges
   AST_READ_OE_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected && read_not_write) ##1 !output_enable_n |-> data_bus_oe)
      else $error("read load did not drive the bus one cycle later");

   AST_LOAD_WRITE_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected && !read_not_write)
      |=> (st.cyc_valid && st.cyc_write && st.cyc_addr == $past(mem_addr)))
      else $error("write load did not become pending one cycle later");

   AST_LOAD_BW_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected) |=> (st.cyc_bw_n == $past(byte_lane_write_n)))
      else $error("lane enables not captured on load");

   AST_ADV_BW_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && advance_or_load && st.burst_active) |=> (st.cyc_bw_n == $past(byte_lane_write_n)))
      else $error("lane enables not captured on advance");

   AST_READ_THEN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected && read_not_write)
      ##1 (enabled && !advance_or_load && selected && !read_not_write)
      |=> (st.cyc_valid && st.cyc_write))
      else $error("write after read lost a cycle");

   AST_WRITE_LANDS_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected && !read_not_write) ##1 (enabled && !st.wr_inhibit)
      |-> array_write)
      else $error("write data not taken one cycle after its load");

   AST_ARRAY_WRITE_PENDING: assert property (@(posedge pclk) disable iff (!presetn)
      array_write |-> (st.cyc_valid && st.cyc_write))
      else $error("array written with no pending write");

   AST_READ_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (st.cyc_valid && !st.cyc_write) |-> !array_write)
      else $error("array written during a read cycle");

   // clock enable hold
   AST_HOLD_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      !enabled |-> !array_write)
      else $error("array written while clock enable was high");

   AST_HOLD_KEEPS_BURST: assert property (@(posedge pclk) disable iff (!presetn)
      !enabled |=> ($stable(st.cyc_bw_n) && $stable(st.base) && $stable(st.addr_hi)))
      else $error("burst state moved while clock enable was high");

   AST_HOLD_NO_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (!enabled && !advance_or_load && selected) |=> $stable(st.cyc_addr))
      else $error("address loaded while clock enable was high");

   // burst counter
   AST_LOAD_STARTS_BURST: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && selected)
      |=> (st.burst_active && st.count == COUNT_RESET && st.base == $past(mem_addr[BURST_W-1:0])))
      else $error("load did not start a burst");

   AST_ADV_COUNTS: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && advance_or_load && st.burst_active) |=> (st.count == $past(st.count) + 2'h1))
      else $error("burst counter did not advance");

   AST_ADV_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && advance_or_load && !st.burst_active) |=> !st.cyc_valid)
      else $error("advance with no burst started a transfer");

   AST_ADV_KEEPS_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && advance_or_load && st.burst_active)
      |=> (st.cyc_addr[ADDR_W-1:BURST_W] == $past(st.addr_hi)))
      else $error("burst changed the upper address bits");

   AST_LINEAR_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && advance_or_load && st.burst_active && !burst_order_select)
      |=> (st.cyc_addr[1:0] == ($past(st.base) + $past(st.count) + 2'h1)))
      else $error("linear burst offset wrong");

   AST_ADV_KEEPS_DIR: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && advance_or_load && st.burst_active) |=> (st.cyc_write == $past(st.cyc_write)))
      else $error("burst changed direction");

   // deselect behaviour
   AST_DESELECT_FLOATS: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && !selected) |=> !data_bus_oe)
      else $error("data bus driven one cycle after deselect");

   AST_DESELECT_NO_BURST: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && !selected) |=> !st.burst_active)
      else $error("burst still active after deselect");

   AST_DESELECT_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && !selected) |=> !st.cyc_write)
      else $error("deselect left a write pending");

   AST_DESELECT_KEEPS_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (enabled && !advance_or_load && !selected && st.cyc_valid && !st.cyc_write && !output_enable_n)
      |-> data_bus_oe)
      else $error("pending read cut by deselect");

   // output drivers
   AST_READ_DRIVES: assert property (@(posedge pclk) disable iff (!presetn)
      (st.cyc_valid && !st.cyc_write && !output_enable_n) |-> (data_bus_oe && data_bus_extra_bits_oe))
      else $error("pending read not driven");

   AST_WRITE_NEVER_DRIVES: assert property (@(posedge pclk) disable iff (!presetn)
      st.cyc_write |-> !data_bus_oe)
      else $error("data bus driven during a write cycle");

   AST_OE_LANES_EQUAL: assert property (@(posedge pclk) disable iff (!presetn)
      data_bus_oe == data_bus_extra_bits_oe)
      else $error("data and extra bit drivers disagree");
endmodule : ztbs_sram
`default_nettype wire
